// ==== astf_core.sv ====
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
`include "astf_defines.svh"
module astf_core (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic sys_rst,
	// Register port.
	input astf_pkg::astf_bus_s bus_req,
	output logic [15:0] bus_rdata,
	// Serial lines.
	input wire logic serial_in_line,
	output logic serial_out_line,
	// One-cycle events that set the outside interrupt flags.
	output logic tx_irq_flag,
	output logic rx_irq_flag
);
	import astf_pkg::*;

	// Bits after the start bit: data, optional parity, stops.
	function automatic logic [3:0] frame_bits(input logic [1:0] fmt, input logic stop2);
		frame_bits = 4'd9 + {3'd0, fmt != `ASTF_FMT_8N} + {3'd0, stop2};
	endfunction

	function automatic logic par_of(input logic [1:0] fmt, input logic [7:0] d);
		par_of = (fmt == `ASTF_FMT_8O) ? ~^d : ^d;
	endfunction

	logic module_on_q, stop_count_select_q;
	logic [1:0] frame_format_select_q;
	logic tx_irq_select_q, break_force_q, tx_permit_q, adden_q, overrun_flag_q;
	logic [1:0] rx_irq_select_q;
	logic [15:0] baud_divisor_q;
	logic wr_mode, wr_sta, wr_tx, wr_brg, rd_rx, rd_sta;

	assign wr_mode = bus_req.wr && bus_req.addr == `ASTF_MODE_OFS;
	assign wr_sta = bus_req.wr && bus_req.addr == `ASTF_STA_OFS;
	assign wr_tx = bus_req.wr && bus_req.addr == `ASTF_TXREG_OFS;
	assign wr_brg = bus_req.wr && bus_req.addr == `ASTF_BRG_OFS;
	assign rd_rx = bus_req.rd && bus_req.addr == `ASTF_RXREG_OFS;
	assign rd_sta = bus_req.rd && bus_req.addr == `ASTF_STA_OFS;

	// Mode register survives a switch-off so re-enabling keeps the setup.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			module_on_q <= 1'b0;
			frame_format_select_q <= `ASTF_FMT_8N;
			stop_count_select_q <= 1'b0;
			baud_divisor_q <= `ASTF_BRG_RST;
		end else begin
			if (wr_mode) begin
				module_on_q <= bus_req.wdata[`ASTF_MODE_ON_BIT];
				frame_format_select_q <= bus_req.wdata[2:1];
				stop_count_select_q <= bus_req.wdata[`ASTF_MODE_STOP_BIT];
			end
			if (wr_brg) begin
				baud_divisor_q <= bus_req.wdata;
			end
		end
	end

	logic rx_push;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_irq_select_q <= 1'b0;
			rx_irq_select_q <= 2'b00;
			adden_q <= 1'b0;
			tx_permit_q <= 1'b0;
			break_force_q <= 1'b0;
		end else begin
			if (wr_sta) begin
				tx_irq_select_q <= bus_req.wdata[`ASTF_STA_TXISEL_BIT];
				rx_irq_select_q <= bus_req.wdata[7:6];
				adden_q <= bus_req.wdata[`ASTF_STA_ADDEN_BIT];
			end
			if (!module_on_q) begin
				tx_permit_q <= 1'b0;
				break_force_q <= 1'b0;
			end else if (wr_sta) begin
				tx_permit_q <= bus_req.wdata[`ASTF_STA_TXEN_BIT];
				break_force_q <= bus_req.wdata[`ASTF_STA_BRK_BIT];
			end
		end
	end

	// Overrun: hardware set wins over a software clear in the same cycle.
	logic rx_done, rx_full;
	always_ff @(posedge core_clk) begin
		if (sys_rst || !module_on_q) begin
			overrun_flag_q <= 1'b0;
		end else if (rx_done && rx_full) begin
			overrun_flag_q <= 1'b1;
		end else if (wr_sta) begin
			overrun_flag_q <= overrun_flag_q & bus_req.wdata[`ASTF_STA_OVERRUN_BIT];
		end
	end

	// Oversampling tick at sixteen times the bit rate.
	logic [15:0] tick_cnt_q;
	logic tick;
	assign tick = module_on_q && tick_cnt_q == baud_divisor_q;
	always_ff @(posedge core_clk) begin
		if (sys_rst || !module_on_q || tick) begin
			tick_cnt_q <= 16'h0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end

	// Transmit queue and shifter.
	astf_char_t tx_mem_q [4];
	logic [1:0] tx_wptr_q, tx_rptr_q;
	logic [2:0] tx_cnt_q;
	logic tx_push, tx_load, tx_busy_q;
	logic [11:0] tx_shifter_q;
	logic [3:0] tx_bits_q, tx_ph_q;
	logic [11:0] tx_frame;
	astf_char_t tx_head;

	assign tx_head = tx_mem_q[tx_rptr_q];
	assign tx_push = wr_tx && module_on_q && tx_cnt_q != `ASTF_QDEPTH;
	assign tx_load = module_on_q && tx_permit_q && !tx_busy_q && tx_cnt_q != 3'd0;

	always_comb begin
		tx_frame = {2'b11, 1'b1, tx_head[7:0], 1'b0};
		case (frame_format_select_q)
			`ASTF_FMT_8E, `ASTF_FMT_8O: tx_frame[9] = par_of(frame_format_select_q, tx_head[7:0]);
			`ASTF_FMT_9N: tx_frame[9] = tx_head[8];
			default: tx_frame[9] = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || !module_on_q) begin
			tx_wptr_q <= 2'd0;
			tx_rptr_q <= 2'd0;
			tx_cnt_q <= 3'd0;
		end else begin
			if (tx_push) begin
				tx_mem_q[tx_wptr_q] <= bus_req.wdata[8:0];
				tx_wptr_q <= tx_wptr_q + 2'd1;
			end
			if (tx_load) begin
				tx_rptr_q <= tx_rptr_q + 2'd1;
			end
			tx_cnt_q <= tx_cnt_q + {2'd0, tx_push} - {2'd0, tx_load};
		end
	end

	// The bit timer starts cleared at load, so the start bit waits sixteen ticks before the first shift.
	always_ff @(posedge core_clk) begin
		if (sys_rst || !module_on_q) begin
			tx_busy_q <= 1'b0;
			tx_shifter_q <= 12'hFFF;
			tx_bits_q <= 4'd0;
			tx_ph_q <= 4'd0;
		end else if (tx_load) begin
			tx_busy_q <= 1'b1;
			tx_shifter_q <= tx_frame;
			tx_bits_q <= frame_bits(frame_format_select_q, stop_count_select_q) + 4'd1;
			tx_ph_q <= 4'd0;
		end else if (tx_busy_q && tick) begin
			tx_ph_q <= tx_ph_q + 4'd1;
			if (tx_ph_q == `ASTF_OVS_LAST) begin
				tx_shifter_q <= {1'b1, tx_shifter_q[11:1]};
				tx_bits_q <= tx_bits_q - 4'd1;
				if (tx_bits_q == 4'd1) begin
					tx_busy_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			serial_out_line <= 1'b1;
			tx_irq_flag <= 1'b0;
		end else begin
			serial_out_line <= !break_force_q && (!tx_busy_q || tx_shifter_q[0]);
			// Break never loads the shifter, so it raises no event.
			tx_irq_flag <= tx_load && (!tx_irq_select_q || tx_cnt_q == 3'd1);
		end
	end

	// Receive side: the line is synchronised before anything looks at it.
	logic rx_s1_q, rx_s2_q;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_in_line;
			rx_s2_q <= rx_s1_q;
		end
	end

	astf_rx_state_e rx_state_q;
	logic [3:0] rx_ph_q, rx_idx_q, rx_last_idx, stop1_idx;
	logic [11:0] rx_shifter_q, rx_fr;
	logic rx_framing_fault, rx_parity_fault;
	astf_rx_word_s rx_word;

	assign rx_last_idx = frame_bits(frame_format_select_q, stop_count_select_q);
	assign rx_done = rx_state_q == RX_FRAME && tick && rx_ph_q == `ASTF_OVS_MID &&
		rx_idx_q == rx_last_idx;
	assign stop1_idx = (frame_format_select_q == `ASTF_FMT_8N) ? 4'd9 : 4'd10;

	always_comb begin
		rx_fr = rx_shifter_q;
		rx_fr[rx_idx_q] = rx_s2_q;
		rx_framing_fault = !rx_fr[stop1_idx] ||
			(stop_count_select_q && !rx_fr[stop1_idx + 4'd1]);
		rx_parity_fault = (frame_format_select_q == `ASTF_FMT_8E ||
			frame_format_select_q == `ASTF_FMT_8O) &&
			rx_fr[9] != par_of(frame_format_select_q, rx_fr[8:1]);
		rx_word.parity_fault = rx_parity_fault;
		rx_word.framing_fault = rx_framing_fault;
		rx_word.data = (frame_format_select_q == `ASTF_FMT_9N) ? rx_fr[9:1] : {1'b0, rx_fr[8:1]};
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || !module_on_q) begin
			rx_state_q <= RX_IDLE;
			rx_ph_q <= 4'd0;
			rx_idx_q <= 4'd0;
			rx_shifter_q <= 12'h000;
		end else begin
			case (rx_state_q)
				RX_IDLE: begin
					if (!rx_s2_q && !overrun_flag_q) begin
						rx_state_q <= RX_FRAME;
						rx_ph_q <= 4'd0;
						rx_idx_q <= 4'd0;
					end
				end
				RX_FRAME: begin
					if (tick) begin
						rx_ph_q <= rx_ph_q + 4'd1;
						if (rx_ph_q == `ASTF_OVS_MID) begin
							rx_shifter_q <= rx_fr;
							rx_idx_q <= rx_idx_q + 4'd1;
							if (rx_idx_q == 4'd0 && rx_s2_q) begin
								rx_state_q <= RX_IDLE;
							end else if (rx_done) begin
								// A break must see the line high again before a new start.
								rx_state_q <= rx_framing_fault ? RX_WAIT_HIGH : RX_IDLE;
							end
						end
					end
				end
				RX_WAIT_HIGH: begin
					if (rx_s2_q) begin
						rx_state_q <= RX_IDLE;
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// Receive queue.
	astf_rx_word_s rx_mem_q [4];
	astf_rx_word_s rx_head;
	logic [1:0] rx_wptr_q, rx_rptr_q;
	logic [2:0] rx_cnt_q, rx_cnt_d;
	logic rx_pop, rx_avail;
	astf_char_t rx_last_q;

	assign rx_head = rx_mem_q[rx_rptr_q];
	assign rx_full = rx_cnt_q == `ASTF_QDEPTH;
	assign rx_avail = rx_cnt_q != 3'd0;
	assign rx_push = rx_done && !rx_full;
	assign rx_pop = rd_rx && rx_avail;
	assign rx_cnt_d = rx_cnt_q + {2'd0, rx_push} - {2'd0, rx_pop};

	always_ff @(posedge core_clk) begin
		if (sys_rst || !module_on_q) begin
			rx_wptr_q <= 2'd0;
			rx_rptr_q <= 2'd0;
			rx_cnt_q <= 3'd0;
			rx_irq_flag <= 1'b0;
		end else begin
			if (rx_push) begin
				rx_mem_q[rx_wptr_q] <= rx_word;
				rx_wptr_q <= rx_wptr_q + 2'd1;
			end
			if (rx_pop) begin
				rx_rptr_q <= rx_rptr_q + 2'd1;
			end
			rx_cnt_q <= rx_cnt_d;
			rx_irq_flag <= rx_push && (!rx_irq_select_q[1] ||
				(!rx_irq_select_q[0] && rx_cnt_d == `ASTF_RX_THR3) ||
				(rx_irq_select_q[0] && rx_cnt_d == `ASTF_QDEPTH));
		end
	end

	// A read of an empty queue answers with the last word taken.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_last_q <= 9'h000;
		end else if (rx_pop) begin
			rx_last_q <= rx_head.data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bus_rdata <= 16'h0000;
		end else begin
			case (bus_req.addr)
				`ASTF_MODE_OFS: bus_rdata <= {module_on_q, 12'h000,
					frame_format_select_q, stop_count_select_q};
				`ASTF_STA_OFS: bus_rdata <= {tx_irq_select_q, 3'h0, break_force_q, tx_permit_q,
					tx_cnt_q == `ASTF_QDEPTH, !tx_busy_q && tx_cnt_q == 3'd0, rx_irq_select_q,
					adden_q, rx_state_q == RX_IDLE, rx_avail && rx_head.parity_fault,
					rx_avail && rx_head.framing_fault, overrun_flag_q,
					rx_avail};
				`ASTF_RXREG_OFS: bus_rdata <= {7'h00, rx_avail ? rx_head.data : rx_last_q};
				`ASTF_BRG_OFS: bus_rdata <= baud_divisor_q;
				default: bus_rdata <= 16'h0000;
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_start_bit;
		tx_busy_q ##1 !serial_out_line;
	endsequence
	sequence s_line_idle;
		(!tx_busy_q && !break_force_q)[*2];
	endsequence

	property p_reset_format;
		$fell(sys_rst) |-> frame_format_select_q == `ASTF_FMT_8N && !stop_count_select_q;
	endproperty
	a_reset_format: assert property (p_reset_format) else $error("format not 8N1 after reset");

	property p_load_starts;
		tx_load && !break_force_q |=> s_start_bit;
	endproperty
	a_load_starts: assert property (p_load_starts) else $error("start bit not sent after load");

	property p_full_drop;
		wr_tx && tx_cnt_q == `ASTF_QDEPTH && !tx_load |=> $stable(tx_wptr_q) && tx_cnt_q == 3'd4;
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("write to full queue accepted");

	property p_tx_event;
		tx_load && (!tx_irq_select_q || tx_cnt_q == 3'd1) |=> tx_irq_flag;
	endproperty
	a_tx_event: assert property (p_tx_event) else $error("transmit event missing");

	property p_tx_no_event;
		!tx_load |=> !tx_irq_flag;
	endproperty
	a_tx_no_event: assert property (p_tx_no_event) else $error("transmit event without load");

	property p_break_low;
		break_force_q |=> !serial_out_line;
	endproperty
	a_break_low: assert property (p_break_low) else $error("line not low during break");

	property p_idle_high;
		s_line_idle |-> serial_out_line;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("idle line not high");

	property p_avail_read;
		rd_sta |=> bus_rdata[0] == $past(rx_avail);
	endproperty
	a_avail_read: assert property (p_avail_read) else $error("data available bit wrong");

	property p_empty_read;
		rd_rx && rx_cnt_q == 3'd0 && !rx_push |=> rx_cnt_q == 3'd0 && bus_rdata[8:0] == $past(rx_last_q);
	endproperty
	a_empty_read: assert property (p_empty_read) else $error("empty read not stale");

	property p_rx_thr3;
		rx_push && rx_irq_select_q == 2'b10 |=> rx_irq_flag == ($past(rx_cnt_d) == 3'd3);
	endproperty
	a_rx_thr3: assert property (p_rx_thr3) else $error("receive event at three wrong");

	property p_off_clears;
		!module_on_q |=> tx_cnt_q == 3'd0 && rx_cnt_q == 3'd0 && !tx_busy_q;
	endproperty
	a_off_clears: assert property (p_off_clears) else $error("queues not cleared when off");
endmodule // astf_core

// ==== astf_defines.svh ====
`ifndef ASTF_DEFINES_SVH
`define ASTF_DEFINES_SVH
`define ASTF_MODE_OFS 16'h020C
`define ASTF_STA_OFS 16'h020E
`define ASTF_TXREG_OFS 16'h0210
`define ASTF_RXREG_OFS 16'h0212
`define ASTF_BRG_OFS 16'h0214
`define ASTF_MODE_ON_BIT 15
`define ASTF_MODE_STOP_BIT 0
`define ASTF_STA_TXISEL_BIT 15
`define ASTF_STA_BRK_BIT 11
`define ASTF_STA_TXEN_BIT 10
`define ASTF_STA_ADDEN_BIT 5
`define ASTF_STA_OVERRUN_BIT 1
`define ASTF_MODE_RST 16'h0000
`define ASTF_STA_RST 16'h0110
`define ASTF_BRG_RST 16'h0000
`define ASTF_FMT_8N 2'h0
`define ASTF_FMT_8E 2'h1
`define ASTF_FMT_8O 2'h2
`define ASTF_FMT_9N 2'h3
`define ASTF_OVS_LAST 4'hF
`define ASTF_OVS_MID 4'h7
`define ASTF_QDEPTH 3'h4
`define ASTF_RX_THR3 3'h3
`endif

// ==== astf_far.sv ====
`timescale 1ns/1ns
module astf_far (
	// Clock.
	input wire logic core_clk,
	// Serial lines as seen from the far end.
	input wire logic serial_out_line,
	output logic serial_in_line,
	// Frame format and divisor that both ends agree on.
	input wire logic [1:0] fmt,
	input wire logic two_stop,
	input wire logic [15:0] divisor
);
	int cyc = 0;
	int last_start = 0;
	logic [9:0] got_q[$];
	int gap_q[$];
	initial serial_in_line = 1'b1;
	always @(posedge core_clk) cyc <= cyc + 1;
	function automatic int nbits();
		return (fmt == 2'h0) ? 8 : 9;
	endfunction
	// Mid-bit sampling keeps a one-clock short first bit harmless; stop lands in bit 9.
	always begin : decode
		logic [9:0] w;
		@(negedge serial_out_line);
		gap_q.push_back(cyc - last_start);
		last_start = cyc;
		w = '0;
		repeat (8 * (divisor + 1)) @(posedge core_clk);
		for (int i = 0; i <= nbits(); i++) begin
			repeat (16 * (divisor + 1)) @(posedge core_clk);
			w[i == nbits() ? 9 : i] = serial_out_line;
		end
		got_q.push_back(w);
	end
	task automatic bit_out(input logic v);
		serial_in_line <= v;
		repeat (16 * (divisor + 1)) @(posedge core_clk);
	endtask
	// Bad parity or a low stop bit goes out only when a test asks for it.
	task automatic send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
		@(posedge core_clk);
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) bit_out(d[i]);
		if (fmt == 2'h3) bit_out(d[8]);
		if (fmt == 2'h1 || fmt == 2'h2) bit_out(^d[7:0] ^ fmt[1] ^ bad_par);
		bit_out(~bad_stop);
		if (two_stop || bad_stop) bit_out(1'b1);
	endtask
endmodule // astf_far

// ==== astf_pkg.sv ====
package astf_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} astf_bus_s;
	typedef logic [8:0] astf_char_t;
	typedef struct packed {
		logic parity_fault;
		logic framing_fault;
		astf_char_t data;
	} astf_rx_word_s;
	typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_WAIT_HIGH} astf_rx_state_e;
endpackage

// ==== tb_top.sv ====
`timescale 1ns/1ns
`include "astf_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
	import astf_pkg::*;
	typedef struct {logic [1:0] fmt; logic two; logic [15:0] brg; logic [8:0] d;
		logic [9:0] exp; int len;} astf_tb_row_s;
	astf_tb_row_s rows[7] = '{
		'{2'h0, 1'b0, 16'h0001, 9'h03C, 10'h23C, 10}, '{2'h0, 1'b0, 16'h0000, 9'h0A5, 10'h2A5, 10},
		'{2'h1, 1'b1, 16'h0000, 9'h0B7, 10'h2B7, 12}, '{2'h2, 1'b0, 16'h0000, 9'h0B7, 10'h3B7, 11},
		'{2'h3, 1'b1, 16'h0000, 9'h1C3, 10'h3C3, 12}, '{2'h1, 1'b0, 16'h0000, 9'h001, 10'h301, 11},
		'{2'h2, 1'b1, 16'h0000, 9'h0FF, 10'h3FF, 12}};
	logic [1:0] sels[4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	astf_bus_s bus_req = '0;
	logic [15:0] bus_rdata;
	logic [15:0] rv;
	logic serial_in_line, serial_out_line, tx_irq_flag, rx_irq_flag;
	logic [1:0] fmt = 2'h0;
	logic two_stop = 1'b0;
	logic [15:0] brg = 16'h0000;
	int n_errors = 0, check_count = 0, cycles = 0, n_tx = 0, n_rx = 0, k, hi;
	always #5 core_clk = ~core_clk;
	astf_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .serial_in_line(serial_in_line),
		.serial_out_line(serial_out_line), .tx_irq_flag(tx_irq_flag), .rx_irq_flag(rx_irq_flag));
	astf_far u_far (.core_clk(core_clk), .serial_out_line(serial_out_line),
		.serial_in_line(serial_in_line), .fmt(fmt), .two_stop(two_stop), .divisor(brg));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		n_tx <= n_tx + (tx_irq_flag === 1'b1);
		n_rx <= n_rx + (rx_irq_flag === 1'b1);
		if (cycles == 40000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 rv = bus_rdata;
	endtask
	task automatic ck_start();
		repeat (3) @(posedge core_clk);
		#1 `CHK("line low", 1'b0, serial_out_line)
	endtask
	task automatic wait_tx(input int n);
		for (int i = 0; i < 4000 && u_far.got_q.size() < n; i++) @(posedge core_clk);
	endtask
	task automatic clr();
		u_far.got_q.delete();
		u_far.gap_q.delete();
	endtask
	task automatic rx_in(input logic [8:0] d, input logic bp, input logic bs);
		u_far.send(d, bp, bs);
		repeat (4) @(posedge core_clk);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`ASTF_MODE_OFS);
		`CHK("mode reset", 16'h0000, rv)
		rd(`ASTF_STA_OFS);
		`CHK("status reset", 16'h0110, rv)
		wr(16'h0216, 16'hFFFF);
		rd(16'h0216);
		`CHK("unmapped", 16'h0000, rv)
		`CHK("idle line", 1'b1, serial_out_line)
		$display("test reset done");
		foreach (rows[i]) begin
			fmt <= rows[i].fmt;
			two_stop <= rows[i].two;
			brg <= rows[i].brg;
			wr(`ASTF_BRG_OFS, rows[i].brg);
			wr(`ASTF_MODE_OFS, {1'b1, 12'h000, rows[i].fmt, rows[i].two});
			wr(`ASTF_STA_OFS, 16'h0400);
			clr();
			k = n_tx;
			wr(`ASTF_TXREG_OFS, {7'h00, rows[i].d});
			ck_start();
			wr(`ASTF_TXREG_OFS, {7'h00, rows[i].d});
			wait_tx(2);
			`CHK("frame a", rows[i].exp, u_far.got_q[0])
			`CHK("frame b", rows[i].exp, u_far.got_q[1])
			hi = (u_far.gap_q[1] + 8 * (rows[i].brg + 1)) / (16 * (rows[i].brg + 1));
			`CHK("frame bits", rows[i].len, hi)
			`CHK("tx events", 2, n_tx - k)
			rx_in(rows[i].d, 1'b0, 1'b0);
			rd(`ASTF_RXREG_OFS);
			`CHK("rx word", rows[i].d, rv[8:0])
		end
		$display("test format table done");
		fmt <= 2'h0;
		two_stop <= 1'b0;
		brg <= 16'h0000;
		wr(`ASTF_BRG_OFS, 16'h0000);
		wr(`ASTF_MODE_OFS, 16'h8000);
		wr(`ASTF_STA_OFS, 16'h8000);
		clr();
		k = n_tx;
		for (int i = 0; i < 5; i++) wr(`ASTF_TXREG_OFS, 16'h0011 + i);
		rd(`ASTF_STA_OFS);
		`CHK("full flag", 1'b1, rv[9])
		wr(`ASTF_STA_OFS, 16'h8400);
		ck_start();
		wait_tx(4);
		repeat (400) @(posedge core_clk);
		`CHK("queued count", 4, u_far.got_q.size())
		for (int i = 0; i < 4; i++) `CHK("queued word", 10'h211 + i, u_far.got_q[i])
		`CHK("tx events on empty", 1, n_tx - k)
		$display("test full queue done");
		k = n_tx;
		hi = 0;
		wr(`ASTF_STA_OFS, 16'h0C00);
		ck_start();
		repeat (224) begin
			@(posedge core_clk);
			hi += (serial_out_line !== 1'b0);
		end
		`CHK("break held", 0, hi)
		wr(`ASTF_STA_OFS, 16'h0400);
		repeat (32) @(posedge core_clk);
		`CHK("line after break", 1'b1, serial_out_line)
		`CHK("break events", 0, n_tx - k)
		$display("test break done");
		foreach (sels[s]) begin
			wr(`ASTF_STA_OFS, {8'h04, sels[s], 6'h00});
			k = n_rx;
			for (int i = 0; i < 4; i++) begin
				rx_in(9'h040 + i, 1'b0, 1'b0);
				`CHK("rx events", (sels[s] < 2) ? i + 1 : (i >= sels[s]), n_rx - k)
			end
			rd(`ASTF_STA_OFS);
			`CHK("data avail", 1'b1, rv[0])
			if (s == 3) begin
				rx_in(9'h0EE, 1'b0, 1'b0);
				rd(`ASTF_STA_OFS);
				`CHK("overrun", 1'b1, rv[1])
			end
			for (int i = 0; i < 5; i++) begin
				rd(`ASTF_RXREG_OFS);
				`CHK("rx queue word", 9'h040 + (i > 3 ? 3 : i), rv[8:0])
			end
			rd(`ASTF_STA_OFS);
			`CHK("data gone", 1'b0, rv[0])
		end
		wr(`ASTF_STA_OFS, 16'h0400);
		rd(`ASTF_STA_OFS);
		`CHK("overrun cleared", 1'b0, rv[1])
		$display("test receive queue done");
		fmt <= 2'h1;
		wr(`ASTF_MODE_OFS, 16'h8002);
		rx_in(9'h033, 1'b1, 1'b0);
		rx_in(9'h034, 1'b0, 1'b1);
		rx_in(9'h035, 1'b0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			rd(`ASTF_STA_OFS);
			`CHK("error flags", 2'h2 >> i, rv[3:2])
			rd(`ASTF_RXREG_OFS);
			`CHK("flagged word", 9'h033 + i, rv[8:0])
		end
		$display("test error flags done");
		fmt <= 2'h0;
		for (int m = 0; m < 2; m++) begin
			wr(`ASTF_MODE_OFS, 16'h8000);
			wr(`ASTF_STA_OFS, 16'h0000);
			wr(`ASTF_TXREG_OFS, 16'h0055);
			wr(`ASTF_TXREG_OFS, 16'h0056);
			rx_in(9'h066, 1'b0, 1'b0);
			if (m == 0)
				wr(`ASTF_MODE_OFS, 16'h0000);
			else begin
				@(posedge core_clk);
				sys_rst <= 1'b1;
				repeat (2) @(posedge core_clk);
				sys_rst <= 1'b0;
			end
			rd(`ASTF_STA_OFS);
			`CHK("status emptied", 16'h0110, rv)
			wr(`ASTF_MODE_OFS, 16'h8000);
			clr();
			wr(`ASTF_STA_OFS, 16'h0400);
			repeat (300) @(posedge core_clk);
			`CHK("nothing sent", 0, u_far.got_q.size())
		end
		$display("test emptying done");
		complete_run();
	end
endmodule // tb_top
